// *** pmc_pkg.sv ***
// Package of constants and types shared by both ends of the margin command unit
//
// Functional notes
// (RQ1) Upper byte 00h off, 80h on
// (RQ2) Command A4h drives margin-high code
// (RQ3) Command 94h drives margin-low code
// (RQ4) Faults set comm fault flag bit 9
// (RQ5) Fault flag stays until host writes one
// (RQ6) Fault register at 78h on any page
// (RQ7) Revision register 98h read-only, reads 2200h
// (RQ8) Protocol detected at power-on, then locked
// (RQ9) Readback only once data-out pin enabled
// (RQ10) Host reads slower than it writes
// (RQ11) Power-down output defaults to high impedance
// (RQ12) Optional power-up at stored code
// (RQ13) Digital outputs only pull low or release
// (RQ14) Margin transitions slew, never step
// (RQ15) Optional bus timeout frees stalled transfers
// (RQ16) Broadcast address answered besides own address
// (RQ17) Operation register 01h, pages 00h-03h
// (RQ18) Page register upper byte, resets 03h
// (RQ19) Command handling only while enable bit set
// (RQ20) Off gives power-down state, on restores
// (RQ21) Unknown command rejected, sets fault flag
package pmc_pkg;
  // Command addresses on the device link
  localparam logic [7:0]  PMC_CMD_PAGE    = 8'h00;
  localparam logic [7:0]  PMC_CMD_OP      = 8'h01;
  localparam logic [7:0]  PMC_CMD_FAULT   = 8'h78;
  localparam logic [7:0]  PMC_CMD_REV     = 8'h98;
  localparam logic [7:0]  PMC_CMD_ICFG    = 8'h26;
  localparam logic [7:0]  PMC_CMD_MHI     = 8'h13;
  localparam logic [7:0]  PMC_CMD_MLO     = 8'h14;
  localparam logic [7:0]  PMC_CMD_NOM     = 8'h1C;
  localparam logic [7:0]  PMC_CMD_SLEW    = 8'h18;
  localparam logic [7:0]  PMC_CMD_PDCFG   = 8'h1F;
  // Operation codes
  localparam logic [7:0]  PMC_OP_OFF      = 8'h00;
  localparam logic [7:0]  PMC_OP_ON       = 8'h80;
  localparam logic [7:0]  PMC_OP_MHI      = 8'hA4;
  localparam logic [7:0]  PMC_OP_MLO      = 8'h94;
  // Field positions and reset values
  localparam int          PMC_FAULT_BIT   = 9;
  localparam int          PMC_EN_BIT      = 8;
  localparam int          PMC_TMO_BIT     = 12;
  localparam int          PMC_SDO_BIT     = 0;
  localparam logic [15:0] PMC_REV_VALUE   = 16'h2200;
  localparam logic [7:0]  PMC_PAGE_RESET  = 8'h03;
  localparam logic [7:0]  PMC_PAGE_LAST   = 8'h03;
  localparam logic [7:0]  PMC_PAGE_BCAST  = 8'hFF;
  // Bus timeout and default slew divider in cycles of aclk
  localparam int          PMC_CLK_MHZ     = 40;
  localparam int          PMC_TMO_US      = 30;
  localparam int          PMC_TMO_CYC     = PMC_TMO_US * PMC_CLK_MHZ;
  localparam int          PMC_SLEW_DIV    = 16;
  // AXI4-Lite register offsets of the host controller
  localparam logic [5:0]  PMC_A_CTRL      = 6'h00;
  localparam logic [5:0]  PMC_A_WDATA     = 6'h04;
  localparam logic [5:0]  PMC_A_STATUS    = 6'h08;
  localparam logic [5:0]  PMC_A_RDATA     = 6'h0C;
  localparam logic [1:0]  PMC_RESP_OK     = 2'h0;
  localparam logic [1:0]  PMC_RESP_SLVERR = 2'h2;
  // Protocols seen at power-on
  typedef enum logic [1:0] {
    PMC_PROTO_NONE = 2'h0,
    PMC_PROTO_PM   = 2'h1,
    PMC_PROTO_OTHER = 2'h3
  } pmc_proto_e;
endpackage : pmc_pkg

// *** pmc_link_if.sv ***
// Interface joining the host controller and the device command unit
`timescale 1ns/10ps
`default_nettype none
interface pmc_link_if;
  // Transfer request from host
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [7:0]  dest;
  logic [15:0] wdata;
  logic [3:0]  clocks;
  // Open-drain answer lines, low enable means pulling low
  logic        ack_oe_n;
  logic [15:0] rdata_oe_n;
  logic        done_oe_n;
  // Resolved wire levels with pullups
  logic        ack;
  logic        done;
  logic [15:0] rdata;
  assign ack   = ack_oe_n;
  assign done  = done_oe_n;
  assign rdata = rdata_oe_n;
  modport dev  (input req, wr, addr, dest, wdata, clocks,
                output ack_oe_n, rdata_oe_n, done_oe_n);
  modport host (output req, wr, addr, dest, wdata, clocks,
                input ack, done, rdata);
endinterface : pmc_link_if
`default_nettype wire

// *** pmc_device.sv ***
// Device end: command decoder, paged channel state, slewed outputs
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pmc_device
  import pmc_pkg::*;
#(
  parameter int          CH_N      = 4,
  parameter int          TMO_CYC   = PMC_TMO_CYC,
  parameter logic [7:0]  OWN_DEST  = 8'h48,
  parameter logic [7:0]  BCAST     = 8'h47
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Link
  pmc_link_if.dev              lnk,
  // Strap and stored settings
  input  wire logic            proto_strap,
  input  wire logic            nvm_pu_code_en,
  input  wire logic [11:0]     nvm_pu_code,
  // Channel outputs
  output logic [CH_N*12-1:0]   ch_code,
  output logic [CH_N-1:0]      ch_hiz
);
  initial begin
    if (CH_N < 1 || CH_N > 4) $error("pmc_device: CH_N must be 1 to 4");
  end
  typedef enum logic [1:0] {PMC_IDLE = 2'b00, PMC_EXEC = 2'b01,
                            PMC_ANS = 2'b11} pmc_st_e;
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the link request and the protocol strap
  logic [2:0]  req_s;
  logic [1:0]  strap_s;
  always_ff @(posedge aclk) begin
    strap_s <= {strap_s[0], proto_strap}; // Fills during reset
    if (!aresetn) begin
      req_s   <= 3'h0;
    end else begin
      req_s   <= {req_s[1:0], lnk.req};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // State
  pmc_st_e            st_reg, st_next;
  pmc_proto_e         proto_reg, proto_next;
  logic [7:0]         page_reg, page_next;
  logic               fault_reg, fault_next;
  logic [15:0]        icfg_reg, icfg_next;
  logic [15:0]        rd_reg, rd_next;
  logic               ack_reg, ack_next;
  logic               done_reg, done_next;
  logic [15:0]        tmo_reg, tmo_next;
  logic [11:0]        mhi_reg [CH_N], mhi_next [CH_N];
  logic [11:0]        mlo_reg [CH_N], mlo_next [CH_N];
  logic [11:0]        nom_reg [CH_N], nom_next [CH_N];
  logic [11:0]        cur_reg [CH_N], cur_next [CH_N];
  logic [7:0]         op_reg  [CH_N], op_next  [CH_N];
  logic [CH_N-1:0]    hiz_reg, hiz_next;
  logic [7:0]         slew_reg, slew_next;
  logic [7:0]         div_reg, div_next;
  logic               pu_done_reg, pu_done_next;
  logic [7:0]         op_b;
  logic               hit, paged, pg_ok, fault_set;
  // Target code from operation state
  function automatic logic [11:0] pmc_target(input logic [7:0] op,
      input logic [11:0] hi, input logic [11:0] lo, input logic [11:0] nm);
    pmc_target = (op == PMC_OP_MHI) ? hi : (op == PMC_OP_MLO) ? lo : nm;
  endfunction : pmc_target
  // Next state of the command engine
  always_comb begin
    st_next = st_reg; proto_next = proto_reg; page_next = page_reg;
    fault_next = fault_reg; icfg_next = icfg_reg; rd_next = rd_reg;
    ack_next = ack_reg; done_next = done_reg; tmo_next = tmo_reg;
    mhi_next = mhi_reg; mlo_next = mlo_reg; nom_next = nom_reg;
    cur_next = cur_reg; op_next = op_reg; hiz_next = hiz_reg;
    slew_next = slew_reg; div_next = div_reg; pu_done_next = pu_done_reg;
    fault_set = 1'b0;
    op_b = lnk.wdata[15:8];
    // (RQ16) broadcast address too
    hit = (lnk.dest == OWN_DEST) || (lnk.dest == BCAST);
    paged = (lnk.addr == PMC_CMD_OP) || (lnk.addr == PMC_CMD_MHI)
         || (lnk.addr == PMC_CMD_MLO) || (lnk.addr == PMC_CMD_NOM);
    pg_ok = (page_reg <= PMC_PAGE_LAST) && (32'(page_reg) < CH_N);
    // (RQ8) lock protocol once
    if (proto_reg == PMC_PROTO_NONE)
      proto_next = strap_s[1] ? PMC_PROTO_PM : PMC_PROTO_OTHER;
    // (RQ12) optional stored power-up code
    if (!pu_done_reg) begin
      pu_done_next = 1'b1;
      for (int i = 0; i < CH_N; i++) begin
        nom_next[i] = nvm_pu_code;
        cur_next[i] = nvm_pu_code;
        hiz_next[i] = !nvm_pu_code_en;
        op_next[i]  = nvm_pu_code_en ? PMC_OP_ON : PMC_OP_OFF;
      end
    end
    unique case (st_reg)
      PMC_IDLE: begin
        if (req_s[1] && !req_s[2] && hit) begin
          st_next = PMC_EXEC;
          tmo_next = 16'h0;
        end
      end
      PMC_EXEC: begin
        st_next = PMC_ANS;
        ack_next = 1'b1; done_next = 1'b1;
        rd_next = 16'h0;
        // (RQ19) handling gated by enable
        if (lnk.addr == PMC_CMD_ICFG)
          icfg_next = lnk.wr ? lnk.wdata : icfg_reg;
        else if (!icfg_reg[PMC_EN_BIT] || proto_reg != PMC_PROTO_PM)
          ack_next = 1'b0;
        // (RQ4) wrong clock count
        else if (lnk.wr && lnk.clocks != 4'h2)
          fault_set = 1'b1;
        // (RQ9) readback needs data-out
        else if (!lnk.wr && !icfg_reg[PMC_SDO_BIT])
          fault_set = 1'b1;
        // (RQ4) paged access bad page
        else if (paged && !pg_ok)
          fault_set = 1'b1;
        else if (lnk.addr == PMC_CMD_PAGE) begin
          // (RQ18) page in upper byte
          if (lnk.wr) page_next = lnk.wdata[15:8];
          rd_next = {page_reg, 8'h00};
        end else if (lnk.addr == PMC_CMD_FAULT) begin
          // (RQ6) any page
          // (RQ5) write one clears
          if (lnk.wr && lnk.wdata[PMC_FAULT_BIT]) fault_next = 1'b0;
          rd_next = 16'(fault_reg) << PMC_FAULT_BIT;
        end else if (lnk.addr == PMC_CMD_REV) begin
          // (RQ7) read-only revision
          if (lnk.wr) fault_set = 1'b1;
          rd_next = PMC_REV_VALUE;
        end else if (lnk.addr == PMC_CMD_SLEW) begin
          if (lnk.wr) slew_next = lnk.wdata[7:0];
          rd_next = {8'h00, slew_reg};
        end else if (lnk.addr == PMC_CMD_MHI) begin
          if (lnk.wr) mhi_next[page_reg[1:0]] = lnk.wdata[15:4];
          rd_next = {mhi_reg[page_reg[1:0]], 4'h0};
        end else if (lnk.addr == PMC_CMD_MLO) begin
          if (lnk.wr) mlo_next[page_reg[1:0]] = lnk.wdata[15:4];
          rd_next = {mlo_reg[page_reg[1:0]], 4'h0};
        end else if (lnk.addr == PMC_CMD_NOM) begin
          if (lnk.wr) nom_next[page_reg[1:0]] = lnk.wdata[15:4];
          rd_next = {nom_reg[page_reg[1:0]], 4'h0};
        end else if (lnk.addr == PMC_CMD_OP) begin
          // (RQ17) paged operation register
          rd_next = {op_reg[page_reg[1:0]], 8'h00};
          if (lnk.wr) begin
            // (RQ1) decode operation byte
            if (op_b == PMC_OP_OFF || op_b == PMC_OP_ON
                || op_b == PMC_OP_MHI || op_b == PMC_OP_MLO) begin
              op_next[page_reg[1:0]] = op_b;
              // (RQ11) off means high impedance
              // (RQ20) on restores output
              hiz_next[page_reg[1:0]] = (op_b == PMC_OP_OFF);
            end else begin
              // (RQ21) reject unknown code
              fault_set = 1'b1;
            end
          end
        end else begin
          // (RQ4) invalid command address
          fault_set = 1'b1;
        end
      end
      PMC_ANS: begin
        done_next = 1'b1;
        tmo_next = tmo_reg + 16'h1;
        // (RQ15) optional timeout release
        if (!req_s[1] || (icfg_reg[PMC_TMO_BIT]
            && 32'(tmo_reg) >= TMO_CYC)) begin
          st_next = PMC_IDLE;
          ack_next = 1'b0;
          done_next = 1'b0;
        end
      end
      default: st_next = PMC_IDLE;
    endcase
    // (RQ4) set beats clear
    if (fault_set) fault_next = 1'b1;
    // (RQ14) slew toward target
    div_next = div_reg + 8'h1;
    if (div_reg >= slew_reg) begin
      div_next = 8'h0;
      for (int i = 0; i < CH_N; i++) begin
        // (RQ2) margin high target
        // (RQ3) margin low target
        if (cur_reg[i] < pmc_target(op_reg[i], mhi_reg[i], mlo_reg[i],
                                    nom_reg[i]))
          cur_next[i] = cur_reg[i] + 12'h1;
        else if (cur_reg[i] > pmc_target(op_reg[i], mhi_reg[i],
                                         mlo_reg[i], nom_reg[i]))
          cur_next[i] = cur_reg[i] - 12'h1;
      end
    end
  end
  // Register the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= PMC_IDLE; proto_reg <= PMC_PROTO_NONE;
      page_reg <= PMC_PAGE_RESET; fault_reg <= 1'b0; icfg_reg <= 16'h0;
      rd_reg <= 16'h0; ack_reg <= 1'b0; done_reg <= 1'b0; tmo_reg <= 16'h0;
      hiz_reg <= '1; slew_reg <= 8'(PMC_SLEW_DIV); div_reg <= 8'h0;
      pu_done_reg <= 1'b0;
      for (int i = 0; i < CH_N; i++) begin
        mhi_reg[i] <= 12'h0; mlo_reg[i] <= 12'h0; nom_reg[i] <= 12'h0;
        cur_reg[i] <= 12'h0; op_reg[i] <= 8'h0;
      end
    end else begin
      st_reg <= st_next; proto_reg <= proto_next; page_reg <= page_next;
      fault_reg <= fault_next; icfg_reg <= icfg_next; rd_reg <= rd_next;
      ack_reg <= ack_next; done_reg <= done_next; tmo_reg <= tmo_next;
      hiz_reg <= hiz_next; slew_reg <= slew_next; div_reg <= div_next;
      pu_done_reg <= pu_done_next;
      mhi_reg <= mhi_next; mlo_reg <= mlo_next; nom_reg <= nom_next;
      cur_reg <= cur_next; op_reg <= op_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // (RQ13) open drain, release means one
  assign lnk.ack_oe_n   = ack_reg;
  assign lnk.done_oe_n  = done_reg;
  assign lnk.rdata_oe_n = rd_reg;
  assign ch_hiz = hiz_reg;
  always_comb begin
    for (int i = 0; i < CH_N; i++) ch_code[i*12 +: 12] = cur_reg[i];
  end
endmodule : pmc_device
`default_nettype wire

// *** pmc_host.sv ***
// Host end: AXI4-Lite slave that issues link transfers to the device
`timescale 1ns/10ps
`default_nettype none
module pmc_host
  import pmc_pkg::*;
#(
  parameter int RD_HOLD = 8,
  parameter int WR_HOLD = 2
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link
  pmc_link_if.host         lnk
);
  initial begin
    if (RD_HOLD <= WR_HOLD) $error("pmc_host: reads must be slower");
  end
  typedef enum logic [1:0] {PMH_IDLE = 2'b00, PMH_REQ = 2'b01,
                            PMH_REL = 2'b11} pmh_st_e;
  ////////////////////////////////////////////////////////////////////////
  // Synchronise open-drain answers
  logic [1:0]  ack_s, done_s;
  logic [15:0] rd_s0, rd_s1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_s <= 2'h0; done_s <= 2'h0; rd_s0 <= 16'h0; rd_s1 <= 16'h0;
    end else begin
      ack_s <= {ack_s[0], lnk.ack}; done_s <= {done_s[0], lnk.done};
      rd_s0 <= lnk.rdata; rd_s1 <= rd_s0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Registers and transfer engine
  pmh_st_e     st_reg, st_next;
  logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic        arr_reg, arr_next, rv_reg, rv_next;
  logic [1:0]  br_reg, br_next;
  logic [5:0]  awa_reg, awa_next;
  logic [31:0] ctrl_reg, ctrl_next, wd_reg, wd_next, rdat_reg, rdat_next;
  logic [31:0] wc_reg, wc_next;
  logic [15:0] lrd_reg, lrd_next;
  logic        busy_reg, busy_next, nak_reg, nak_next;
  logic        aw_seen_reg, aw_seen_next, w_seen_reg, w_seen_next;
  logic [7:0]  hold_reg, hold_next;
  logic        req_reg, req_next;
  logic [31:0] w_val;
  always_comb begin
    st_next = st_reg; awr_next = awr_reg; wr_next = wr_reg; bv_next = bv_reg;
    arr_next = arr_reg; rv_next = rv_reg; br_next = br_reg;
    awa_next = awa_reg; ctrl_next = ctrl_reg; wd_next = wd_reg;
    rdat_next = rdat_reg; lrd_next = lrd_reg; busy_next = busy_reg;
    nak_next = nak_reg; aw_seen_next = aw_seen_reg; w_seen_next = w_seen_reg;
    hold_next = hold_reg; req_next = req_reg; wc_next = wc_reg;
    w_val = 32'h0;
    // Address and data taken in either order
    awr_next = !aw_seen_reg && !bv_reg;
    wr_next  = !w_seen_reg && !bv_reg;
    if (s_axi_awvalid && awr_reg) begin
      aw_seen_next = 1'b1; awr_next = 1'b0; awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      w_seen_next = 1'b1; wr_next = 1'b0; wc_next = s_axi_wdata;
    end
    if (aw_seen_reg && w_seen_reg && !bv_reg) begin
      aw_seen_next = 1'b0; w_seen_next = 1'b0; bv_next = 1'b1;
      br_next = PMC_RESP_OK;
      w_val = wc_reg;
      if (awa_reg == PMC_A_CTRL && !busy_reg) begin
        ctrl_next = w_val; busy_next = w_val[31];
        if (w_val[31]) nak_next = 1'b0;
      end else if (awa_reg == PMC_A_WDATA)
        wd_next = w_val;
      else
        br_next = PMC_RESP_SLVERR;
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    // One read at a time
    arr_next = !rv_reg && !arr_reg;
    if (s_axi_arvalid && arr_reg) begin
      arr_next = 1'b0; rv_next = 1'b1;
      unique case (s_axi_araddr)
        PMC_A_CTRL:   rdat_next = ctrl_reg;
        PMC_A_STATUS: rdat_next = {30'h0, nak_reg, busy_reg};
        PMC_A_RDATA:  rdat_next = {16'h0, lrd_reg};
        default:      rdat_next = 32'h0;
      endcase
    end
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    // Link sequencer; ctrl: 31 go, 24 write, 23:16 dest, 15:8 cmd, 3:0 clks
    unique case (st_reg)
      PMH_IDLE: if (busy_reg) begin
        st_next = PMH_REQ; req_next = 1'b1; hold_next = 8'h0;
      end
      PMH_REQ: begin
        hold_next = hold_reg + 8'h1;
        // (RQ10) slower pacing on reads
        if (done_s[1] && 32'(hold_reg) >= (ctrl_reg[24] ? WR_HOLD : RD_HOLD))
        begin
          st_next = PMH_REL; req_next = 1'b0;
          nak_next = !ack_s[1]; lrd_next = rd_s1;
        end else if (hold_reg == 8'hFF) begin
          st_next = PMH_REL; req_next = 1'b0; nak_next = 1'b1;
        end
      end
      PMH_REL: if (!done_s[1]) begin
        st_next = PMH_IDLE; busy_next = 1'b0;
      end
      default: st_next = PMH_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= PMH_IDLE; awr_reg <= 1'b0; wr_reg <= 1'b0; bv_reg <= 1'b0;
      arr_reg <= 1'b0; rv_reg <= 1'b0; br_reg <= PMC_RESP_OK;
      awa_reg <= 6'h0; ctrl_reg <= 32'h0; wd_reg <= 32'h0;
      rdat_reg <= 32'h0; lrd_reg <= 16'h0; busy_reg <= 1'b0;
      nak_reg <= 1'b0; aw_seen_reg <= 1'b0; w_seen_reg <= 1'b0;
      hold_reg <= 8'h0; req_reg <= 1'b0; wc_reg <= 32'h0;
    end else begin
      st_reg <= st_next; awr_reg <= awr_next; wr_reg <= wr_next;
      bv_reg <= bv_next; arr_reg <= arr_next; rv_reg <= rv_next;
      br_reg <= br_next; awa_reg <= awa_next; ctrl_reg <= ctrl_next;
      wd_reg <= wd_next; rdat_reg <= rdat_next; lrd_reg <= lrd_next;
      busy_reg <= busy_next; nak_reg <= nak_next;
      aw_seen_reg <= aw_seen_next; w_seen_reg <= w_seen_next;
      hold_reg <= hold_next; req_reg <= req_next; wc_reg <= wc_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, rresp tied to OK; command fields held from ctrl while busy, wdata from wd_reg
  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rdat_reg;
  assign s_axi_rresp   = PMC_RESP_OK;
  assign lnk.req    = req_reg;
  assign lnk.wr     = ctrl_reg[24];
  assign lnk.dest   = ctrl_reg[23:16];
  assign lnk.addr   = ctrl_reg[15:8];
  assign lnk.clocks = ctrl_reg[3:0];
  assign lnk.wdata  = wd_reg[15:0];
endmodule : pmc_host
`default_nettype wire

// *** pmc_link_assertions.sv ***
// Link checks between the host controller and the device command unit
`timescale 1ns/10ps
`default_nettype none
module pmc_link_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link wires
  input wire logic        req,
  input wire logic        wr,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0]  clocks,
  input wire logic        ack,
  input wire logic        done,
  input wire logic [15:0] rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] cfg_reg;
  logic [1:0] cfg_next;
  // Shadow of enable and readback bits, so refusals can be predicted
  always_comb begin
    cfg_next = cfg_reg;
    if (done && ack && wr && addr == 8'h26 && clocks == 4'h2) begin
      cfg_next = {wdata[8], wdata[0]};
    end
  end
  // Cleared by reset like the device's own configuration
  always_ff @(posedge aclk) begin
    cfg_reg <= aresetn ? cfg_next : 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_answer_time;
    $rose(req) |-> ##[1:12] done;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("no answer");
  property p_done_stands;
    done && req |=> done;
  endproperty
  a_done_stands: assert property (p_done_stands) else $error("answer cut");
  property p_done_drop;
    $fell(req) |-> ##[1:6] !done;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("answer stuck");
  property p_done_end;
    $fell(done) |-> !req;
  endproperty
  a_done_end: assert property (p_done_end) else $error("early release");
  property p_ack_done;
    ack |-> done;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack alone");
  property p_rev_read;
    done && ack && !wr && addr == 8'h98 && cfg_reg[0] |-> rdata == 16'h2200;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("bad revision");
  property p_disabled;
    $rose(done) && !cfg_reg[1] && addr != 8'h26 |-> !ack;
  endproperty
  a_disabled: assert property (p_disabled) else $error("ack when off");
  property p_rdata_stable;
    done && req ##1 req |-> $stable(rdata);
  endproperty
  a_rdata_stable: assert property (p_rdata_stable) else $error("data moved");
  // Main traffic kinds
  c_write: cover property (done && ack && wr);
  c_read: cover property (done && ack && !wr);
  c_refuse: cover property ($rose(done) && !ack);
endmodule : pmc_link_assertions
`default_nettype wire

// *** pmc_margin_command_unit_tb_top.sv ***
// Testbench joining host and device ends over the link
`timescale 1ns/10ps
`default_nettype none
module pmc_margin_command_unit_tb_top;
  import pmc_pkg::*;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        nvm_pu_code_en = 1'b0;
  logic [11:0] nvm_pu_code = 12'h000;
  logic [47:0] ch_code;
  logic [3:0]  ch_hiz;
  logic        nak_v;
  logic [15:0] q_v;
  int          failures = 0, compares = 0;
  pmc_link_if lnk ();
  pmc_host i_pmc_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lnk(lnk));
  pmc_device #(.TMO_CYC(20)) i_pmc_device (.aclk, .aresetn, .lnk(lnk),
    .proto_strap(1'b1), .nvm_pu_code_en, .nvm_pu_code, .ch_code, .ch_hiz);
  pmc_link_assertions i_chk (.aclk, .aresetn, .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .clocks(lnk.clocks), .ack(lnk.ack),
    .done(lnk.done), .rdata(lnk.rdata));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // A used-up bound is a hang, so the run closes at once
  task automatic guard(int n, int lim);
    if (n >= lim) begin
      failures++;
      test_done();
    end
  endtask : guard
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  // Each valid is released only at the edge where its ready is seen, bready and rready at the edge where their valid is seen
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    guard(n, 200);
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    d = s_axi_rdata;
    guard(n, 200);
  endtask : axi_rd
  // One link transfer: data word, go, poll busy, fetch answer
  task automatic op(input logic w, input logic [7:0] cmd,
      input logic [15:0] d, input logic [3:0] c = 4'h2,
      input logic [7:0] dst = 8'h48);
    logic [31:0] v;
    int n;
    axi_wr(PMC_A_WDATA, {16'h0000, d});
    axi_wr(PMC_A_CTRL, {1'b1, 6'h00, w, dst, cmd, 4'h0, c});
    n = 0;
    do begin
      axi_rd(PMC_A_STATUS, v);
      n++;
    end while (v[0] !== 1'b0 && n < 50);
    guard(n, 50);
    nak_v = v[1];
    axi_rd(PMC_A_RDATA, v);
    q_v = v[15:0];
  endtask : op
  task automatic fault_is(logic f);
    op(1'b0, 8'h78, 16'h0000);
    check("fault flag", 16'(q_v[9]), 16'(f));
    op(1'b1, 8'h78, 16'h0200);
  endtask : fault_is
  task automatic wait_code(logic [11:0] c);
    int n;
    n = 0;
    while (ch_code[11:0] !== c && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    check("slewed code", 16'(ch_code[11:0]), 16'(c));
  endtask : wait_code
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_config();
    check("hiz at reset", 16'(ch_hiz), 16'h000F);
    op(1'b0, 8'h98, 16'h0000);
    check("refused off", 16'(nak_v), 16'h0001);
    op(1'b1, 8'h26, 16'h0100);
    op(1'b0, 8'h98, 16'h0000);
    op(1'b1, 8'h26, 16'h0101);
    fault_is(1'b1);
    fault_is(1'b0);
    op(1'b0, 8'h98, 16'h0000);
    check("revision", q_v, 16'h2200);
    op(1'b0, 8'h00, 16'h0000);
    check("page reset", 16'(q_v[15:8]), 16'h0003);
    op(1'b1, 8'h98, 16'h1234);
    fault_is(1'b1);
    op(1'b0, 8'h98, 16'h0000, 4'h2, 8'h47);
    check("broadcast rev", q_v, 16'h2200);
  endtask : t_config
  task automatic t_ops();
    op(1'b1, 8'h00, 16'h0000);
    op(1'b1, 8'h18, 16'h0001);
    op(1'b1, 8'h13, 16'hABC0);
    op(1'b1, 8'h14, 16'h1230);
    op(1'b1, 8'h01, 16'h8000);
    check("on drives", 16'(ch_hiz[0]), 16'h0000);
    op(1'b1, 8'h01, 16'hA400);
    check("no step", 16'(ch_code[11:0] === 12'hABC), 16'h0000);
    wait_code(12'hABC);
    op(1'b1, 8'h01, 16'h9400);
    wait_code(12'h123);
    op(1'b1, 8'h01, 16'h5500);
    fault_is(1'b1);
    check("code kept", 16'(ch_code[11:0]), 16'h0123);
    op(1'b1, 8'h01, 16'h0000, 4'h3);
    fault_is(1'b1);
    op(1'b1, 8'h01, 16'h0000);
    check("off hiz", 16'(ch_hiz[0]), 16'h0001);
    op(1'b1, 8'h00, 16'h0400);
    op(1'b1, 8'h01, 16'h8000);
    fault_is(1'b1);
  endtask : t_ops
  task automatic t_powerup();
    nvm_pu_code_en <= 1'b1;
    nvm_pu_code <= 12'h5A5;
    do_reset();
    repeat (3) @(posedge aclk);
    check("stored hiz", 16'(ch_hiz[0]), 16'h0000);
    check("stored code", 16'(ch_code[11:0]), 16'h05A5);
  endtask : t_powerup
  initial begin
    do_reset();
    t_config();
    t_ops();
    t_powerup();
    test_done();
  end
endmodule : pmc_margin_command_unit_tb_top
`default_nettype wire
